// ==== inc/pps_pkg.sv ====
// package for the partner path status word block
package pps_pkg;
    // interface codes
    localparam logic [1:0] IF_ETHERNET_PORT_A = 2'h0;
    localparam logic [1:0] IF_ETHERNET_PORT_B = 2'h1;
    localparam logic [1:0] IF_ETHERNET_PORT_C = 2'h2;
    localparam logic [1:0] IF_SERIAL_WIDE_AREA_PORT = 2'h3;
    // send buffer occupancy codes
    localparam logic [1:0] BUF_NORMAL = 2'h0;
    localparam logic [1:0] BUF_ABOVE_90 = 2'h1;
    localparam logic [1:0] BUF_OVERFLOW = 2'h3;
    localparam int BUF_HIGH_PERCENT = 90;
    // lower byte field positions
    localparam int PB_REACHABLE = 0;
    localparam int PB_ALL_PATHS = 1;
    localparam int PB_BUF_LO = 2;
    localparam int PB_RESERVED = 4;
    localparam int PB_TEMP_REACH = 5;
    localparam int PB_TEMP_MODE = 6;
    localparam int PB_REDUNDANT = 7;
    // upper byte field positions
    localparam int QB_MAIN_STAT = 8;
    localparam int QB_SUB_STAT = 10;
    localparam int QB_MAIN_IF = 12;
    localparam int QB_SUB_IF = 14;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam int NUM_IF = 4;
    localparam int APB_ID = 0;
    // apb register byte addresses
    localparam logic [7:0] A_WORD = 8'h00;
    localparam logic [7:0] A_CFG = 8'h04;
    localparam logic [7:0] A_IRQ_STAT = 8'h08;
    localparam logic [7:0] A_IRQ_MASK = 8'h0c;
    localparam logic [1:0] CFG_RESET = 2'h0;

    // per-interface live link state
    typedef struct packed {
        logic [3:0] up;          // partner reachable over each interface
        logic [3:0] in_use;      // interface currently carrying the traffic
    } pps_link_t;

    // per-partner configuration
    typedef struct packed {
        logic [1:0] main_if;
        logic [1:0] sub_if;
        logic temp_mode;
    } pps_cfg_t;
endpackage

// ==== core/pps_status_word.sv ====
// partner path status word builder with apb access
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
module pps_status_word #(
    parameter int FILL_WIDTH = 8
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire pps_pkg::pps_link_t link_i,
    input wire logic partner_closed_i,
    input wire logic [FILL_WIDTH-1:0] fill_pct_i,
    input wire logic overflow_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic [15:0] status_word_o,
    output logic irq_o
);
    pps_pkg::pps_cfg_t cfg;
    logic [15:0] next_word;
    logic [15:0] word;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [15:0] word_prev;
    logic overflow_prev;
    logic main_up, sub_up, main_use, sub_use, redundant;
    logic reach, temp_reach;
    logic [1:0] buf_code;
    logic wr, rd_hit;
    logic cfg_hit, mask_hit, stat_hit;
    logic word_changed, ovf_rise;
    logic [1:0] irq_set, irq_clr;
    logic [31:0] next_rdata;

    // pick the live state of one interface by its code
    function automatic logic if_bit(input logic [3:0] v, input logic [1:0] code);
        return v[code];
    endfunction

    // only two paths, both local interfaces of this device
    always_comb begin
        redundant = (cfg.main_if != cfg.sub_if);
        main_up = if_bit(link_i.up, cfg.main_if);
        main_use = if_bit(link_i.in_use, cfg.main_if);
        sub_up = redundant && if_bit(link_i.up, cfg.sub_if);
        sub_use = redundant && if_bit(link_i.in_use, cfg.sub_if);
    end

    // reachability; a temporary partner that closed itself, with no link in use, counts as reachable
    always_comb begin
        temp_reach = cfg.temp_mode && partner_closed_i && (link_i.in_use == 4'h0);
        reach = main_up || sub_up || temp_reach;
    end

    // buffer fill code, overflow has priority over the high mark
    always_comb begin
        if (overflow_i) begin
            buf_code = pps_pkg::BUF_OVERFLOW;
        end else if (32'(fill_pct_i) > pps_pkg::BUF_HIGH_PERCENT) begin
            buf_code = pps_pkg::BUF_ABOVE_90;
        end else begin
            buf_code = pps_pkg::BUF_NORMAL;
        end
    end

    // assemble the word, low byte partner, high byte path
    always_comb begin
        next_word = pps_pkg::WORD_RESET;
        next_word[pps_pkg::PB_REACHABLE] = reach;
        next_word[pps_pkg::PB_ALL_PATHS] = main_up && (sub_up || !redundant);
        next_word[pps_pkg::PB_BUF_LO +: 2] = buf_code;
        next_word[pps_pkg::PB_RESERVED] = 1'b0;
        next_word[pps_pkg::PB_TEMP_REACH] = temp_reach;
        next_word[pps_pkg::PB_TEMP_MODE] = cfg.temp_mode;
        next_word[pps_pkg::PB_REDUNDANT] = redundant;
        next_word[pps_pkg::QB_MAIN_STAT] = main_up;
        next_word[pps_pkg::QB_MAIN_STAT + 1] = main_use;
        next_word[pps_pkg::QB_SUB_STAT] = sub_up;
        next_word[pps_pkg::QB_SUB_STAT + 1] = sub_use;
        next_word[pps_pkg::QB_MAIN_IF +: 2] = cfg.main_if;
        next_word[pps_pkg::QB_SUB_IF +: 2] = cfg.sub_if;
    end

    // word register refreshes every enabled cycle, one cycle behind inputs
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            word <= pps_pkg::WORD_RESET;
        end else if (clk_en_i) begin
            word <= next_word;
        end
    end
    assign status_word_o = word;

    // apb handshake: zero wait states, so pready can stay high
    assign wr = psel_i && penable_i && pwrite_i;
    assign pready_o = 1'b1;

    // address decode shared by the write and error paths; the read mux compares paddr_i itself
    always_comb begin
        cfg_hit = (paddr_i == pps_pkg::A_CFG);
        mask_hit = (paddr_i == pps_pkg::A_IRQ_MASK);
        stat_hit = (paddr_i == pps_pkg::A_IRQ_STAT);
        rd_hit = (paddr_i == pps_pkg::A_WORD) || cfg_hit || stat_hit || mask_hit;
    end

    // error only in the access phase; an unmapped write is dropped, a read gives zero
    assign pslverr_o = psel_i && penable_i && !rd_hit;

    // configuration register steers the path selection
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg <= '0;
        end else if (clk_en_i && wr && cfg_hit) begin
            cfg.main_if <= pwdata_i[1:0];
            cfg.sub_if <= pwdata_i[3:2];
            cfg.temp_mode <= pwdata_i[4];
        end
    end

    // interrupt mask, same layout as the sticky status
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_mask <= 2'h0;
        end else if (clk_en_i && wr && mask_hit) begin
            irq_mask <= pwdata_i[1:0];
        end
    end

    // event strobes: bit0 any change of the word, bit1 overflow going high
    always_comb begin
        word_changed = (word != word_prev);
        ovf_rise = overflow_i && !overflow_prev;
        irq_set = {ovf_rise, word_changed};
        irq_clr = (wr && stat_hit) ? pwdata_i[1:0] : 2'h0;
    end

    // history for the edge detectors; resets like the word, so no false change event
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            word_prev <= pps_pkg::WORD_RESET;
            overflow_prev <= 1'b0;
        end else if (clk_en_i) begin
            word_prev <= word;
            overflow_prev <= overflow_i;
        end
    end

    // sticky status, write one to clear; set is or-ed last so it beats a clear
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_stat <= 2'h0;
        end else if (clk_en_i) begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
        end
    end

    // level interrupt, high while an unmasked event is pending
    assign irq_o = |(irq_stat & irq_mask);

    // read mux; unmapped offsets read as zero
    always_comb begin
        case (paddr_i)
            pps_pkg::A_WORD: next_rdata = {16'h0, word};
            pps_pkg::A_CFG: next_rdata = {27'h0, cfg.temp_mode, cfg.sub_if, cfg.main_if};
            pps_pkg::A_IRQ_STAT: next_rdata = {30'h0, irq_stat};
            pps_pkg::A_IRQ_MASK: next_rdata = {30'h0, irq_mask};
            default: next_rdata = 32'h0;
        endcase
    end

    // read data taken in the setup cycle so it stands through the access phase;
    // an event landing in the access cycle shows on the next read, bits are sticky
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_o <= 32'h0;
        end else if (clk_en_i && psel_i && !penable_i) begin
            prdata_o <= next_rdata;
        end
    end

    // checks on the word layout itself
    a_reserved_zero: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        word[pps_pkg::PB_RESERVED] == 1'b0) else $error("reserved bit set");
    a_single_if_sub: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        word[15:14] == word[13:12] |-> word[11:10] == 2'h0 && !word[7])
        else $error("substitute status with one path");
    a_refresh_word: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i |=> word == $past(next_word)) else $error("word not refreshed");
    a_reach_main: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        word[8] |-> word[0]) else $error("path up but partner unreachable");
    a_all_paths: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        word[1] |-> word[8] && (word[10] || !word[7])) else $error("all paths wrong");
    a_buf_ovf: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && overflow_i |=> word[3:2] == 2'h3) else $error("overflow code");
    a_buf_code: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        word[3:2] != 2'h2) else $error("illegal buffer code");
    a_temp_reach: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        word[5] |-> word[6] && word[0]) else $error("temporary reach wrong");
    a_redund_flag: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        word[7] == (word[15:14] != word[13:12])) else $error("redundancy flag");

    // main path field follows its interface one enabled cycle later, the substitute field only while the two codes differ
    a_main_path: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i
        |=> word[9:8] == $past({link_i.in_use[cfg.main_if], link_i.up[cfg.main_if]}))
        else $error("main path status wrong");
    a_sub_path: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && (cfg.main_if != cfg.sub_if)
        |=> word[11:10] == $past({link_i.in_use[cfg.sub_if], link_i.up[cfg.sub_if]}))
        else $error("substitute path status wrong");
    a_sub_quiet: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && (cfg.main_if == cfg.sub_if)
        |=> word[11:10] == 2'h0 && !word[7])
        else $error("substitute bits set with one interface");
    a_if_codes: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i
        |=> word[15:12] == $past({cfg.sub_if, cfg.main_if}))
        else $error("interface codes wrong");
    a_mode_bit: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i |=> word[6] == $past(cfg.temp_mode))
        else $error("connection mode bit wrong");

    // reachability from the live path state
    a_reach_path: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && link_i.up[cfg.main_if] |=> word[0] && word[8])
        else $error("main path up but not reachable");
    a_all_reach: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && link_i.up[cfg.main_if] && link_i.up[cfg.sub_if]
        |=> word[1])
        else $error("all paths up but flag low");
    a_not_all: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && !link_i.up[cfg.main_if] |=> !word[1] && !word[8])
        else $error("main path down but flagged up");
    a_temp_closed: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && cfg.temp_mode && partner_closed_i && (link_i.in_use == 4'h0)
        |=> word[5] && word[0])
        else $error("closed temporary partner not reachable");
    a_temp_open: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && (link_i.in_use != 4'h0) |=> !word[5])
        else $error("temporary reach with a link open");
    a_temp_perm: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && !cfg.temp_mode |=> !word[5] && !word[6])
        else $error("temporary bits in permanent mode");

    // buffer fill code below overflow
    a_buf_high: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && !overflow_i && (32'(fill_pct_i) > pps_pkg::BUF_HIGH_PERCENT)
        |=> word[3:2] == pps_pkg::BUF_ABOVE_90)
        else $error("high mark code wrong");
    a_buf_normal: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && !overflow_i && (32'(fill_pct_i) <= pps_pkg::BUF_HIGH_PERCENT)
        |=> word[3:2] == pps_pkg::BUF_NORMAL)
        else $error("normal fill code wrong");

    // freeze and sticky events
    a_frozen_word: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        !clk_en_i |=> $stable(word))
        else $error("word moved with clock enable low");
    a_word_event: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && word_changed |=> irq_stat[0])
        else $error("word change not flagged");
    a_ovf_event: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && ovf_rise |=> irq_stat[1])
        else $error("overflow rise not flagged");
    a_w1c_clear: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && wr && stat_hit && pwdata_i[0] && !word_changed
        |=> !irq_stat[0])
        else $error("change flag not cleared");

    // register access
    a_cfg_write: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && wr && cfg_hit
        |=> {cfg.temp_mode, cfg.sub_if, cfg.main_if} == $past(pwdata_i[4:0]))
        else $error("configuration write lost");
    a_cfg_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && !(wr && cfg_hit) |=> $stable(cfg))
        else $error("configuration changed without a write");
    a_mask_write: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && wr && mask_hit
        |=> irq_mask == $past(pwdata_i[1:0]))
        else $error("mask write lost");
    a_read_word: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && psel_i && !penable_i && (paddr_i == pps_pkg::A_WORD)
        |=> prdata_o == {16'h0, $past(word)})
        else $error("word read data wrong");
    a_unmapped_zero: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        clk_en_i && psel_i && !penable_i && !rd_hit
        |=> prdata_o == 32'h0)
        else $error("unmapped read not zero");
endmodule

// ==== test/pps_cpu_model.sv ====
// controller cpu side: keeps its own copy of the status word
`timescale 1ns/1ns
module pps_cpu_model (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [15:0] status_word_i,
    output logic [15:0] tag_o
);
    // copy refreshed every clock, like a scan cycle that never skips
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) tag_o <= 16'h0000;
        else tag_o <= status_word_i;
    end
endmodule

// ==== test/tb_partner_path_status_word.sv ====
// random and corner stimulus for the partner path status word block
`timescale 1ns/1ns
module tb_partner_path_status_word;
    logic mclk_i = 0, reset_n_i = 0, clk_en_i = 1, closed = 0, ovf = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready_o, pslverr_o, irq_o, e;
    logic [7:0] paddr = 8'h00, fill = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata_o, r;
    logic [15:0] status_word_o, tag;
    logic [4:0] c;
    pps_pkg::pps_link_t link = '0;
    pps_pkg::pps_link_t lk;
    int mismatches = 0, n_tests = 0;
    pps_status_word u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
        .link_i(link), .partner_closed_i(closed), .fill_pct_i(fill), .overflow_i(ovf),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .status_word_o(status_word_o), .irq_o(irq_o));
    pps_cpu_model u_cpu (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .status_word_i(status_word_o), .tag_o(tag));
    initial forever #2 mclk_i = ~mclk_i;
    task automatic print_verdict();
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer; waits on pready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk_i);
        penable <= 1;
        n = 0;
        do begin @(posedge mclk_i); n++; end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) mismatches++;
        r = prdata_o;
        e = pslverr_o;
        psel <= 0; penable <= 0;
    endtask
    // word worked out from configuration and live inputs
    function automatic logic [15:0] exp_word(logic [4:0] k, pps_pkg::pps_link_t l);
        logic [1:0] m, s;
        logic tr;
        logic [15:0] w;
        m = k[1:0]; s = k[3:2];
        tr = k[4] & closed & ~|l.in_use;
        w = 16'h0000;
        w[0] = l.up[m] | l.up[s] | tr;
        w[1] = l.up[m] & l.up[s];
        w[3:2] = ovf ? pps_pkg::BUF_OVERFLOW : (fill > 8'(pps_pkg::BUF_HIGH_PERCENT)
            ? pps_pkg::BUF_ABOVE_90 : pps_pkg::BUF_NORMAL);
        w[5] = tr; w[6] = k[4]; w[7] = (m != s);
        w[9:8] = {l.in_use[m], l.up[m]};
        w[11:10] = (m != s) ? {l.in_use[s], l.up[s]} : 2'h0;
        w[13:12] = m; w[15:14] = s;
        return w;
    endfunction
    initial begin
        void'($urandom(73));
        repeat (6) @(posedge mclk_i);
        reset_n_i <= 1;
        check("reset word", status_word_o, 32'h0);
        // every interface code as main path, equal codes now and then
        for (int i = 0; i < 48; i++) begin
            c = 5'($urandom());
            c[1:0] = 2'(i);
            if (i % 4 == 1) c[3:2] = c[1:0];
            lk = 8'($urandom());
            // corner: temporary partner that hung up, no link open
            if (i % 8 == 5) begin
                c[4] = 1'b1;
                lk.in_use = 4'h0;
            end
            apb(1, pps_pkg::A_CFG, {27'h0, c});
            link <= lk;
            closed <= (i % 8 == 5) ? 1'b1 : 1'($urandom());
            ovf <= (i % 7 == 3);
            fill <= (i % 3 == 0) ? 8'd90 : (i % 3 == 1) ? 8'd91 : 8'($urandom_range(100));
            repeat (2) @(posedge mclk_i);
            #1 check("word", status_word_o, exp_word(c, link));
            apb(0, pps_pkg::A_WORD, 0);
            check("apb word", r, {16'h0, exp_word(c, link)});
            check("word err", e, 0);
            apb(0, pps_pkg::A_CFG, 0);
            check("apb cfg", r, {27'h0, c});
        end
        // frozen while clock enable is low
        clk_en_i <= 0; link <= ~link;
        repeat (3) @(posedge mclk_i);
        #1 check("frozen", status_word_o, exp_word(c, ~link));
        clk_en_i <= 1;
        apb(0, 8'h40, 0);
        check("unmapped err", e, 1);
        check("unmapped data", r, 0);
        // interrupt: mask, clear, then overflow rise
        ovf <= 0;
        apb(1, pps_pkg::A_IRQ_MASK, 32'h3);
        apb(1, pps_pkg::A_IRQ_STAT, 32'h3);
        apb(0, pps_pkg::A_IRQ_STAT, 0);
        check("irq clear", r, 0);
        check("irq low", irq_o, 0);
        ovf <= 1;
        repeat (3) @(posedge mclk_i);
        apb(0, pps_pkg::A_IRQ_STAT, 0);
        check("irq set", r, 32'h3);
        check("irq high", irq_o, 1);
        check("cpu copy", tag, exp_word(c, link));
        apb(1, pps_pkg::A_IRQ_MASK, 32'h0);
        #1 check("irq masked", irq_o, 0);
        // second reset in mid-run: configuration falls back to one main path
        @(posedge mclk_i);
        reset_n_i <= 0;
        repeat (2) @(posedge mclk_i);
        reset_n_i <= 1;
        #1 check("reset word 2", status_word_o, 32'h0);
        apb(0, pps_pkg::A_CFG, 0);
        check("reset cfg", r, 0);
        check("word after reset", status_word_o, exp_word(5'h0, link));
        print_verdict();
    end
endmodule
